// ===== src/ppc_pkg.sv
package ppc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] PIN_CTL_ADDR = 8'h18;
    localparam logic [7:0] PATH_CTL_ADDR = 8'h19;

    localparam logic [7:0] PIN_CTL_RST = 8'hC0;
    localparam logic [7:0] PATH_CTL_RST = 8'h20;

    // Fields of the pin function control register.
    localparam int PIN_CHARGE_CURRENT_SET_PIN_EN_BIT = 7;
    localparam int PIN_ILIM_EN_BIT = 6;
    localparam int PIN_PG_DIS_BIT = 5;
    localparam int PIN_STAT_DIS_BIT = 4;
    localparam int PIN_STAT4_FORCE_BIT = 3;
    localparam int PIN_STAT3_FORCE_BIT = 2;
    localparam int PIN_STATUS_OUT_TWO_FORCE_BIT = 1;
    localparam int PIN_STATUS_OUT_ONE_FORCE_BIT = 0;

    // Fields of the power path and reverse control register.
    localparam int PATH_REG_RESET_BIT = 7;
    localparam int PATH_LOAD_EN_BIT = 6;
    localparam int PATH_PFM_EN_BIT = 5;
    localparam int PATH_BATSW_OFF_BIT = 4;
    localparam int PATH_DRIVE_LOW_BIT = 3;
    localparam int PATH_DIODE_BIT = 2;
    localparam int PATH_AUTO_REV_BIT = 1;
    localparam int PATH_REV_BIT = 0;

    // Fields that each reset event returns to default.
    localparam logic [7:0] PIN_WDOG_MASK = 8'hC0;
    localparam logic [7:0] PATH_WDOG_MASK = 8'h4B;
    localparam logic [7:0] PATH_PLUG_MASK = 8'h11;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic enableStatus4;
        logic powerGoodStatus3;
        logic statusTwo;
        logic statusOne;
    } ppc_od_t;

    typedef struct packed {
        logic [7:0] pinCtl;
        logic [7:0] pathCtl;
        logic [7:0] rdData;
        ppc_od_t pinPull;
        logic regResetPulse;
    } ppc_state_t;

endpackage

// ===== src/ppc_regs.sv
`timescale 1ns/100ps
module ppc_regs (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic watchdogExpired,
    input wire logic adapterPlugIn,
    input wire logic syncDetected,
    input wire logic chargeEnablePinDisable,
    input wire ppc_pkg::ppc_od_t functionPullLow,
    output ppc_pkg::ppc_od_t pinOut,
    output ppc_pkg::ppc_od_t pinOe,
    output logic registerResetPulse,
    output logic chargeCurrentPinEnable,
    output logic inputLimitPinEnable,
    output logic powerGoodPinDisable,
    output logic statusPinsDisable,
    output logic inputLoadEnable,
    output logic lightLoadPulseSkipEnable,
    output logic batterySwitchForceOff,
    output logic pathGateDriveLowSelect,
    output logic batterySwitchDiodeMode,
    output logic autoReverseEnable,
    output logic reverseModeEnable
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    ppc_pkg::ppc_state_t state_ff;
    ppc_pkg::ppc_state_t nxt_state;

    logic pinWrite;
    logic pathWrite;
    logic [3:0] disableVec;
    logic [3:0] forceVec;
    logic [3:0] funcVec;
    logic [3:0] pullVec;

    assign pinWrite = regWrEn && (regAddr == ppc_pkg::PIN_CTL_ADDR);
    assign pathWrite = regWrEn && (regAddr == ppc_pkg::PATH_CTL_ADDR);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.regResetPulse = 1'b0;

        // Reads return the contents before any write in the same cycle.
        if (regRdEn) begin
            unique case (regAddr)
                ppc_pkg::PIN_CTL_ADDR: begin
                    nxt_state.rdData = state_ff.pinCtl;
                end
                ppc_pkg::PATH_CTL_ADDR: begin
                    // The restore bit never holds a 1, so it reads as 0.
                    nxt_state.rdData = state_ff.pathCtl;
                end
                default: begin
                    nxt_state.rdData = 8'h00;
                end
            endcase
        end

        // Host writes to the pin register store every field as written, force bits included,
        // whatever the interlock state is; a watchdog expiry in the same cycle still resets bits 7:6.
        if (pinWrite) begin
            nxt_state.pinCtl = regWrData;
        end

        if (pathWrite) begin
            if (regWrData[ppc_pkg::PATH_REG_RESET_BIT]) begin
                // Restore wins over the rest of the written byte.
                nxt_state.pinCtl = ppc_pkg::PIN_CTL_RST;
                nxt_state.pathCtl = ppc_pkg::PATH_CTL_RST;
                nxt_state.regResetPulse = 1'b1;
            end else begin
                nxt_state.pathCtl = regWrData;
            end
        end

        // Watchdog expiry touches only the fields it owns; the force bits,
        // pin disables, diode mode and pulse mode are left alone.
        if (watchdogExpired) begin
            nxt_state.pinCtl = (nxt_state.pinCtl & ~ppc_pkg::PIN_WDOG_MASK)
                | (ppc_pkg::PIN_CTL_RST & ppc_pkg::PIN_WDOG_MASK);
            nxt_state.pathCtl = (nxt_state.pathCtl & ~ppc_pkg::PATH_WDOG_MASK)
                | (ppc_pkg::PATH_CTL_RST & ppc_pkg::PATH_WDOG_MASK);
        end

        // Adapter plug-in drops the battery switch override and reverse mode.
        if (adapterPlugIn) begin
            nxt_state.pathCtl = (nxt_state.pathCtl & ~ppc_pkg::PATH_PLUG_MASK)
                | (ppc_pkg::PATH_CTL_RST & ppc_pkg::PATH_PLUG_MASK);
        end

        // A valid sync clock clears pulse mode, but a host write of 1 in the
        // same cycle is the host forcing pulse mode and is kept.
        if (syncDetected) begin
            if (!(pathWrite && regWrData[ppc_pkg::PATH_PFM_EN_BIT])) begin
                nxt_state.pathCtl[ppc_pkg::PATH_PFM_EN_BIT] = 1'b0;
            end
        end

        // Pin drive is computed from the next register values so that it
        // changes in the same cycle as the controlling bits.
        nxt_state.pinPull = pullVec;
    end

    // ----------------------------------------
    // Open-drain pin selection
    // ----------------------------------------
    // Bit order matches ppc_od_t: status4, status3, status two, status one.
    assign disableVec = {
        chargeEnablePinDisable,
        nxt_state.pinCtl[ppc_pkg::PIN_PG_DIS_BIT],
        nxt_state.pinCtl[ppc_pkg::PIN_STAT_DIS_BIT],
        nxt_state.pinCtl[ppc_pkg::PIN_STAT_DIS_BIT]
    };

    assign forceVec = {
        nxt_state.pinCtl[ppc_pkg::PIN_STAT4_FORCE_BIT],
        nxt_state.pinCtl[ppc_pkg::PIN_STAT3_FORCE_BIT],
        nxt_state.pinCtl[ppc_pkg::PIN_STATUS_OUT_TWO_FORCE_BIT],
        nxt_state.pinCtl[ppc_pkg::PIN_STATUS_OUT_ONE_FORCE_BIT]
    };

    assign funcVec = functionPullLow;

    // A disabled pin follows its force bit; an enabled one follows its own
    // function, and a stored force bit waits there without effect.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            assign pullVec[gi] = disableVec[gi] ? forceVec[gi] : funcVec[gi];
        end
    endgenerate

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_ff.pinCtl <= ppc_pkg::PIN_CTL_RST;
            state_ff.pathCtl <= ppc_pkg::PATH_CTL_RST;
            state_ff.rdData <= 8'h00;
            state_ff.pinPull <= 4'h0;
            state_ff.regResetPulse <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign regRdData = state_ff.rdData;
    assign registerResetPulse = state_ff.regResetPulse;

    // Open-drain pins only ever pull low; the enable carries the level.
    assign pinOut = 4'h0;
    assign pinOe = state_ff.pinPull;

    assign chargeCurrentPinEnable = state_ff.pinCtl[ppc_pkg::PIN_CHARGE_CURRENT_SET_PIN_EN_BIT];
    assign inputLimitPinEnable = state_ff.pinCtl[ppc_pkg::PIN_ILIM_EN_BIT];
    assign powerGoodPinDisable = state_ff.pinCtl[ppc_pkg::PIN_PG_DIS_BIT];
    assign statusPinsDisable = state_ff.pinCtl[ppc_pkg::PIN_STAT_DIS_BIT];

    assign inputLoadEnable = state_ff.pathCtl[ppc_pkg::PATH_LOAD_EN_BIT];
    assign lightLoadPulseSkipEnable = state_ff.pathCtl[ppc_pkg::PATH_PFM_EN_BIT];
    assign batterySwitchForceOff = state_ff.pathCtl[ppc_pkg::PATH_BATSW_OFF_BIT];
    assign pathGateDriveLowSelect = state_ff.pathCtl[ppc_pkg::PATH_DRIVE_LOW_BIT];
    assign batterySwitchDiodeMode = state_ff.pathCtl[ppc_pkg::PATH_DIODE_BIT];
    assign autoReverseEnable = state_ff.pathCtl[ppc_pkg::PATH_AUTO_REV_BIT];
    // Reverse mode ends when this bit clears: by host write, restore, watchdog expiry or adapter plug-in.
    assign reverseModeEnable = state_ff.pathCtl[ppc_pkg::PATH_REV_BIT];

endmodule

// ===== tb/ppc_regs_sva.sv
`timescale 1ns/100ps
module ppc_regs_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic syncDetected,
    input wire logic watchdogExpired,
    input wire logic adapterPlugIn,
    input wire logic chargeEnablePinDisable,
    input wire ppc_pkg::ppc_od_t functionPullLow,
    input wire ppc_pkg::ppc_od_t pinOe,
    input wire logic registerResetPulse,
    input wire logic chargeCurrentPinEnable,
    input wire logic inputLimitPinEnable,
    input wire logic powerGoodPinDisable,
    input wire logic statusPinsDisable,
    input wire logic inputLoadEnable,
    input wire logic lightLoadPulseSkipEnable,
    input wire logic batterySwitchForceOff,
    input wire logic pathGateDriveLowSelect,
    input wire logic autoReverseEnable,
    input wire logic reverseModeEnable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic pathWr = regWrEn && regAddr == 8'h19;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_wdog; watchdogExpired |=> chargeCurrentPinEnable && inputLimitPinEnable
        && !inputLoadEnable && !pathGateDriveLowSelect && !autoReverseEnable; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog fields wrong");
    property p_hold; watchdogExpired && !regWrEn |=> $stable(statusPinsDisable); endproperty
    a_hold: assert property (p_hold) else $error("status disable lost");
    property p_plug; adapterPlugIn |=> !batterySwitchForceOff && !reverseModeEnable; endproperty
    a_plug: assert property (p_plug) else $error("plug-in fields wrong");
    property p_sync; syncDetected && !(pathWr && (regWrData[5] || regWrData[7]))
        |=> !lightLoadPulseSkipEnable; endproperty
    a_sync: assert property (p_sync) else $error("sync did not clear");
    property p_restore; pathWr && regWrData[7] |=> (registerResetPulse && chargeCurrentPinEnable
        && !statusPinsDisable && lightLoadPulseSkipEnable) ##1 !registerResetPulse; endproperty
    a_restore: assert property (p_restore) else $error("restore wrong");
    property p_st4; !$past(reset) && !$past(chargeEnablePinDisable)
        |-> pinOe.enableStatus4 == $past(functionPullLow.enableStatus4); endproperty
    a_st4: assert property (p_st4) else $error("status4 forced");
    property p_st3; !$past(reset) && !powerGoodPinDisable
        |-> pinOe.powerGoodStatus3 == $past(functionPullLow.powerGoodStatus3); endproperty
    a_st3: assert property (p_st3) else $error("status3 forced");
    property p_st1; !$past(reset) && !statusPinsDisable
        |-> pinOe.statusOne == $past(functionPullLow.statusOne); endproperty
    a_st1: assert property (p_st1) else $error("status one forced");
    c_wdog: cover property (watchdogExpired);
    c_sync_wr: cover property (syncDetected && pathWr);
    c_restore: cover property (pathWr && regWrData[7]);
endmodule
bind ppc_regs ppc_regs_sva ppc_regs_sva_i (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .syncDetected(syncDetected),
    .watchdogExpired(watchdogExpired), .adapterPlugIn(adapterPlugIn),
    .chargeEnablePinDisable(chargeEnablePinDisable), .functionPullLow(functionPullLow),
    .pinOe(pinOe), .registerResetPulse(registerResetPulse),
    .chargeCurrentPinEnable(chargeCurrentPinEnable), .inputLimitPinEnable(inputLimitPinEnable),
    .powerGoodPinDisable(powerGoodPinDisable), .statusPinsDisable(statusPinsDisable),
    .inputLoadEnable(inputLoadEnable), .lightLoadPulseSkipEnable(lightLoadPulseSkipEnable),
    .batterySwitchForceOff(batterySwitchForceOff), .pathGateDriveLowSelect(pathGateDriveLowSelect),
    .autoReverseEnable(autoReverseEnable), .reverseModeEnable(reverseModeEnable));

// ===== tb/ppc_regs_bench.sv
`timescale 1ns/100ps
module ppc_regs_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic watchdogExpired = 1'b0;
    logic adapterPlugIn = 1'b0;
    logic syncDetected = 1'b0;
    logic chargeEnablePinDisable = 1'b0;
    ppc_pkg::ppc_od_t functionPullLow = 4'h0;
    ppc_pkg::ppc_od_t pinOe;
    ppc_pkg::ppc_od_t pinOut;
    logic [7:0] regRdData;
    logic [10:0] ctl;
    logic registerResetPulse;
    int nMismatch = 0;
    int samplesChecked = 0;
    int cycles = 0;
    ppc_regs ppc_regs_i (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .watchdogExpired(watchdogExpired), .adapterPlugIn(adapterPlugIn),
        .syncDetected(syncDetected), .chargeEnablePinDisable(chargeEnablePinDisable),
        .functionPullLow(functionPullLow), .pinOut(pinOut), .pinOe(pinOe),
        .registerResetPulse(registerResetPulse), .chargeCurrentPinEnable(ctl[10]),
        .inputLimitPinEnable(ctl[9]), .powerGoodPinDisable(ctl[8]), .statusPinsDisable(ctl[7]),
        .inputLoadEnable(ctl[6]), .lightLoadPulseSkipEnable(ctl[5]),
        .batterySwitchForceOff(ctl[4]), .pathGateDriveLowSelect(ctl[3]),
        .batterySwitchDiodeMode(ctl[2]), .autoReverseEnable(ctl[1]), .reverseModeEnable(ctl[0]));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        // The idle cycle keeps back-to-back reads from toggling the strobe twice at once.
        @(negedge core_clk);
        check({3'h0, regRdData}, {3'h0, exp});
    endtask
    task automatic report_and_stop;
        $display("mismatches=%0d checks=%0d", nMismatch, samplesChecked);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // The ceiling leaves ample slack over the forty-three cycles the sequence needs.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            nMismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        rd(8'h18, 8'hC0);
        rd(8'h19, 8'h20);
        rd(8'h1A, 8'h00);
        chargeEnablePinDisable = 1'b1;
        wr(8'h18, 8'h3F);
        check({7'h0, pinOe}, 11'h00F);
        check({7'h0, pinOut}, 11'h000);
        check(ctl, 11'h1A0);
        @(negedge core_clk);
        functionPullLow = 4'h5;
        chargeEnablePinDisable = 1'b0;
        wr(8'h18, 8'h0F);
        check({7'h0, pinOe}, 11'h005);
        rd(8'h18, 8'h0F);
        functionPullLow = 4'h0;
        wr(8'h18, 8'h3F);
        @(negedge core_clk);
        wr(8'h19, 8'h7F);
        check(ctl, 11'h1FF);
        watchdogExpired = 1'b1;
        @(negedge core_clk);
        watchdogExpired = 1'b0;
        rd(8'h18, 8'hFF);
        rd(8'h19, 8'h34);
        adapterPlugIn = 1'b1;
        @(negedge core_clk);
        adapterPlugIn = 1'b0;
        rd(8'h19, 8'h24);
        syncDetected = 1'b1;
        @(negedge core_clk);
        syncDetected = 1'b0;
        rd(8'h19, 8'h04);
        syncDetected = 1'b1;
        wr(8'h19, 8'h24);
        syncDetected = 1'b0;
        rd(8'h19, 8'h24);
        watchdogExpired = 1'b1;
        wr(8'h18, 8'h00);
        watchdogExpired = 1'b0;
        rd(8'h18, 8'hC0);
        wr(8'h19, 8'h04);
        rd(8'h19, 8'h04);
        wr(8'h19, 8'h80);
        check({10'h0, registerResetPulse}, 11'h001);
        rd(8'h18, 8'hC0);
        rd(8'h19, 8'h20);
        report_and_stop();
    end
endmodule
